// *** common/lqt_pkg.sv ***
// constants for the link quality threshold access port
// assumes a 32-bit avalon-mm slave with byte addresses and one clock
package lqt_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_DATA  = 5'h00;
   localparam logic [4:0] OFF_WARN  = 5'h04;
   localparam logic [4:0] OFF_IST   = 5'h08;
   localparam logic [4:0] OFF_IMASK = 5'h0C;
   localparam logic [4:0] OFF_CTRL  = 5'h10;

   // data port fields
   localparam int BIT_CAPTURE = 13;
   localparam int BIT_STROBE  = 12;
   localparam int SEL_MSB     = 11;
   localparam int SEL_LSB     = 9;
   localparam int BIT_SIDE    = 8;
   localparam int BYTE_MSB    = 7;
   localparam int RESV_MSB    = 15;
   localparam int RESV_LSB    = 14;

   // ctrl fields
   localparam int BIT_PDOWN = 0;

   // interrupt status fields
   localparam int IRQ_W       = 3;
   localparam int IRQ_WARN    = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_SAMPLE  = 2;

   // warning flags: 2*m is low, 2*m+1 is high, last is variance high
   localparam int N_MET  = 5;
   localparam int WARN_W = 11;
   localparam int WARN_VAR = 10;

   // reset values
   localparam logic [7:0]  RST_LIMIT_BYTE = 8'h80;
   localparam logic [7:0]  RST_LO_THR     = 8'h00;
   localparam logic [7:0]  RST_HI_THR     = 8'hFF;
   localparam logic [7:0]  RST_VAR_THR    = 8'hFF;
   localparam logic [2:0]  RST_IMASK      = 3'h0;

   typedef enum logic [2:0] {
      MS_EQ_COEF = 3'b000,
      MS_DGAIN   = 3'b001,
      MS_BLW     = 3'b010,
      MS_FOFF    = 3'b011,
      MS_FCTL    = 3'b100,
      MS_VAR     = 3'b101,
      MS_UNDEF6  = 3'b110,
      MS_UNDEF7  = 3'b111
   } lqt_metric_t;
endpackage

// *** hw/lqt_cmp.sv ***
// low and high bound comparator for a monitored metric
// assumes value and bounds are unsigned and synchronous to the clock
module lqt_cmp #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] lo_bound,
   input  wire logic [W-1:0] hi_bound,
   output wire logic         lo_hit,
   output wire logic         hi_hit
);
   // a bound at the extreme value never fires, which disables it
   assign lo_hit = value < lo_bound;
   assign hi_hit = value > hi_bound;
endmodule

// *** hw/lqt_top.sv ***
// threshold access port of the 100 Mb link quality monitor
// assumes avalon-mm master on CLK, live metrics synchronous to CLK
// Contract
// - bits 15:14 of the data port ignore writes and read as zero
// - writing capture bit 13 as one samples the selected metric, enables sample reads
// - writing strobe bit 12 as one stores the limit byte into selected threshold
// - strobe holds nothing; reads of bit 12 return zero
// - selector 11:9 decodes coefficient, gain, wander, offset, control, variance
// - one selector serves sampling and threshold access alike
// - side bit 8 picks low threshold at zero, high at one
// - for variance, side picks variance bits 23:16 or 31:24 of high threshold
// - limit byte resets to 0x80; capture, selector and side reset to zero
// - with capture clear, written limit byte is data for the selected threshold
// - with capture clear, limit byte reads the selected stored threshold
// - with capture set, limit byte reads the sample, held until a new capture
// - no threshold writes accepted in power-down
// - bound crossing sets high or low warning flag, cleared on its read
module lqt_top
   import lqt_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [4:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   output logic             IRQ,
   input  wire logic [7:0]  EQUALIZER_COEFFICIENT,
   input  wire logic [7:0]  DIGITAL_GAIN_LEVEL,
   input  wire logic [7:0]  BASELINE_WANDER,
   input  wire logic [7:0]  FREQ_OFFSET,
   input  wire logic [7:0]  FREQ_CONTROL,
   input  wire logic [31:0] VARIANCE
);

   logic              wait_ff;
   logic [31:0]       rdata_ff;
   logic              irq_ff;
   logic              capture_ff;
   lqt_metric_t       sel_ff;
   logic              side_ff;
   logic [7:0]        limit_byte_ff;
   logic [7:0]        sample_ff;
   logic              pdown_ff;
   logic [WARN_W-1:0] warn_ff;
   logic [IRQ_W-1:0]  ist_ff;
   logic [IRQ_W-1:0]  imask_ff;
   logic [7:0]        lo_thr_ff [N_MET];
   logic [7:0]        hi_thr_ff [N_MET];
   logic [7:0]        var_thr_ff [2];

   // bus decode
   wire logic req     = READ | WRITE;
   wire logic take    = req & ~wait_ff;
   wire logic wr_take = WRITE & take;
   wire logic rd_take = READ & take;
   wire logic rd_prep = READ & wait_ff;
   wire logic hit_data  = ADDRESS == OFF_DATA;
   wire logic hit_warn  = ADDRESS == OFF_WARN;
   wire logic hit_ist   = ADDRESS == OFF_IST;
   wire logic hit_imask = ADDRESS == OFF_IMASK;
   wire logic hit_ctrl  = ADDRESS == OFF_CTRL;
   wire logic be0 = BYTEENABLE[0];
   wire logic be1 = BYTEENABLE[1];

   // effective fields of a data port write
   wire logic data_wr  = wr_take & hit_data;
   wire logic ctl_wr   = data_wr & be1;
   wire lqt_metric_t new_sel =
      ctl_wr ? lqt_metric_t'(WRITEDATA[SEL_MSB:SEL_LSB]) : sel_ff;
   wire logic new_side = ctl_wr ? WRITEDATA[BIT_SIDE] : side_ff;
   wire logic [7:0] new_byte =
      (data_wr & be0) ? WRITEDATA[BYTE_MSB:0] : limit_byte_ff;

   // strobe is acted on, never stored; capture is stored as written
   wire logic store_req = ctl_wr & WRITEDATA[BIT_STROBE];
   wire logic sel_ok    = new_sel <= MS_VAR;
   wire logic thr_we    = store_req & sel_ok & ~pdown_ff;
   wire logic refused   = store_req & pdown_ff;
   wire logic cap_start = ctl_wr & WRITEDATA[BIT_CAPTURE];

   // live metric selection, one mux that feeds only the sample register
   wire logic [7:0] live_b [N_MET];
   assign live_b[0] = EQUALIZER_COEFFICIENT;
   assign live_b[1] = DIGITAL_GAIN_LEVEL;
   assign live_b[2] = BASELINE_WANDER;
   assign live_b[3] = FREQ_OFFSET;
   assign live_b[4] = FREQ_CONTROL;

   // metrics come in as arguments, else the net would only follow the selector
   function automatic logic [7:0] live_pick(input lqt_metric_t s, input logic sd,
                                            input logic [31:0] v, input logic [39:0] m);
      logic [7:0] r;
      r = 8'h00;
      unique case (s)
         MS_EQ_COEF: r = m[7:0];
         MS_DGAIN:   r = m[15:8];
         MS_BLW:     r = m[23:16];
         MS_FOFF:    r = m[31:24];
         MS_FCTL:    r = m[39:32];
         MS_VAR:     r = sd ? v[31:24] : v[23:16];
         MS_UNDEF6:  r = 8'h00;
         MS_UNDEF7:  r = 8'h00;
      endcase
      return r;
   endfunction

   wire logic [7:0] live_sel = live_pick(new_sel, new_side, VARIANCE,
      {live_b[4], live_b[3], live_b[2], live_b[1], live_b[0]});

   // stored threshold addressed by selector and side
   wire logic [2:0] idx = 3'(sel_ff);
   wire logic [7:0] thr_byte =
      (sel_ff == MS_VAR) ? var_thr_ff[side_ff] :
      (sel_ff > MS_VAR)  ? 8'h00 :
      side_ff ? hi_thr_ff[idx] : lo_thr_ff[idx];

   // limit byte read view depends on capture mode
   wire logic [7:0] rd_byte = capture_ff ? sample_ff : thr_byte;
   wire logic [15:0] data_view = {2'b00, capture_ff, 1'b0, 3'(sel_ff),
                                  side_ff, rd_byte};

   wire logic [31:0] rd_mux =
      hit_data  ? {16'h0000, data_view} :
      hit_warn  ? {21'h00_0000, warn_ff} :
      hit_ist   ? {29'h0000_0000, ist_ff} :
      hit_imask ? {29'h0000_0000, imask_ff} :
      hit_ctrl  ? {31'h0000_0000, pdown_ff} :
      32'h0000_0000;

   // comparators
   wire logic [WARN_W-1:0] hits;
   genvar g;
   generate
      for (g = 0; g < N_MET; g++) begin : g_cmp
         lqt_cmp #(.W(8)) u_cmp (
            .value    (live_b[g]),
            .lo_bound (lo_thr_ff[g]),
            .hi_bound (hi_thr_ff[g]),
            .lo_hit   (hits[2*g]),
            .hi_hit   (hits[2*g+1])
         );
      end
   endgenerate

   // variance has only a high bound
   lqt_cmp #(.W(16)) u_cmp_var (
      .value    (VARIANCE[31:16]),
      .lo_bound (16'h0000),
      .hi_bound ({var_thr_ff[1], var_thr_ff[0]}),
      .lo_hit   (),
      .hi_hit   (hits[WARN_VAR])
   );

   // clear only bits that the answer carried, so a late set survives
   wire logic [WARN_W-1:0] warn_clr =
      (rd_take & hit_warn) ? rdata_ff[WARN_W-1:0] : '0;
   wire logic [WARN_W-1:0] nxt_warn = (warn_ff & ~warn_clr) | hits;

   wire logic [IRQ_W-1:0] ev = {cap_start, refused, |(hits & ~warn_ff)};
   wire logic [IRQ_W-1:0] ist_clr =
      (wr_take & hit_ist & be0) ? WRITEDATA[IRQ_W-1:0] : '0;
   wire logic [IRQ_W-1:0] nxt_ist  = (ist_ff & ~ist_clr) | ev;
   wire logic [IRQ_W-1:0] nxt_mask =
      (wr_take & hit_imask & be0) ? WRITEDATA[IRQ_W-1:0] : imask_ff;

   // one wait cycle per request, answer stands at the taken edge
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff  <= ~(req & wait_ff);
         rdata_ff <= rd_prep ? rd_mux : rdata_ff;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         capture_ff    <= 1'b0;
         sel_ff        <= MS_EQ_COEF;
         side_ff       <= 1'b0;
         limit_byte_ff <= RST_LIMIT_BYTE;
      end else begin
         capture_ff    <= ctl_wr ? WRITEDATA[BIT_CAPTURE] : capture_ff;
         sel_ff        <= new_sel;
         side_ff       <= new_side;
         limit_byte_ff <= new_byte;
      end
   end

   // sample taken once per capture write, then held
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sample_ff <= 8'h00;
      end else if (cap_start) begin
         sample_ff <= live_sel;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < N_MET; i++) begin
            lo_thr_ff[i] <= RST_LO_THR;
            hi_thr_ff[i] <= RST_HI_THR;
         end
         var_thr_ff[0] <= RST_VAR_THR;
         var_thr_ff[1] <= RST_VAR_THR;
      end else if (thr_we) begin
         if (new_sel == MS_VAR) begin
            var_thr_ff[new_side] <= new_byte;
         end else if (new_side) begin
            hi_thr_ff[3'(new_sel)] <= new_byte;
         end else begin
            lo_thr_ff[3'(new_sel)] <= new_byte;
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pdown_ff <= 1'b0;
         warn_ff  <= '0;
         ist_ff   <= '0;
         imask_ff <= RST_IMASK;
         irq_ff   <= 1'b0;
      end else begin
         pdown_ff <= (wr_take & hit_ctrl & be0) ? WRITEDATA[BIT_PDOWN] : pdown_ff;
         warn_ff  <= nxt_warn;
         ist_ff   <= nxt_ist;
         imask_ff <= nxt_mask;
         irq_ff   <= |(nxt_ist & nxt_mask);
      end
   end

   assign READDATA    = rdata_ff;
   assign WAITREQUEST = wait_ff;
   assign IRQ         = irq_ff;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   sequence s_data_read;
      rd_prep && hit_data;
   endsequence

   sequence s_answer;
      !wait_ff && READ;
   endsequence

   a_resv_zero: assert property (
      s_data_read |=> s_answer ##0 (READDATA[RESV_MSB:RESV_LSB] == 2'b00))
      else $error("reserved data port bits read nonzero");

   a_strobe_zero: assert property (
      s_data_read |=> READDATA[BIT_STROBE] == 1'b0)
      else $error("strobe bit read back as one");

   a_thr_readback: assert property (
      (s_data_read ##0 !capture_ff) |=> READDATA[BYTE_MSB:0] == $past(thr_byte))
      else $error("stored threshold not returned");

   a_undef_zero: assert property (
      (s_data_read ##0 (sel_ff > MS_VAR) && !capture_ff) |=> READDATA[BYTE_MSB:0] == 8'h00)
      else $error("undefined selector read nonzero");

   a_sample_take: assert property (
      cap_start |=> capture_ff && sample_ff == $past(live_sel))
      else $error("capture did not sample the selected metric");

   a_sample_hold: assert property (
      (capture_ff && !cap_start) [*2] |-> $stable(sample_ff))
      else $error("sample changed without a new capture");

   a_store_bound: assert property (
      (thr_we && new_sel < MS_VAR && new_side) |=>
         hi_thr_ff[$past(3'(new_sel))] == $past(new_byte))
      else $error("high threshold not stored");

   a_store_low: assert property (
      (thr_we && new_sel < MS_VAR && !new_side) |=>
         lo_thr_ff[$past(3'(new_sel))] == $past(new_byte))
      else $error("low threshold not stored");

   a_var_store: assert property (
      (thr_we && new_sel == MS_VAR) |=> var_thr_ff[$past(new_side)] == $past(new_byte))
      else $error("variance threshold byte not stored");

   a_pdown_block: assert property (
      (store_req && pdown_ff) |-> !thr_we ##1 ist_ff[IRQ_REFUSED])
      else $error("threshold written in power-down");

   a_warn_sets: assert property (
      (|hits) |=> (warn_ff & $past(hits)) == $past(hits))
      else $error("warning flag not set on crossing");

   a_irq_level: assert property (
      (|(ist_ff & imask_ff)) && !(wr_take && hit_ist) |-> IRQ)
      else $error("interrupt low with unmasked status");
endmodule

// *** verification/tb_link_quality_threshold_access.sv ***
// self-checking bench for the threshold access port, with a reference model in the bench
// assumes lqt_top on one 10 MHz clock, avalon-mm slave, bench drives every port itself
module tb_link_quality_threshold_access
   import lqt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk;
   logic        nrst;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        irq;
   logic [7:0]  met [5];
   logic [31:0] variance;
   logic [7:0]  lo_m [6];
   logic [7:0]  hi_m [6];
   logic [31:0] rd;
   logic [2:0]  sel;
   logic        side;
   logic [7:0]  b;
   logic [3:0]  be;
   int          n_errors;
   int          n_tests;

   lqt_top i_dut (
      .CLK(clk), .NRST(nrst), .ADDRESS(address), .READ(read), .WRITE(write),
      .WRITEDATA(writedata), .BYTEENABLE(be), .READDATA(readdata),
      .WAITREQUEST(waitrequest), .IRQ(irq), .EQUALIZER_COEFFICIENT(met[0]),
      .DIGITAL_GAIN_LEVEL(met[1]), .BASELINE_WANDER(met[2]), .FREQ_OFFSET(met[3]),
      .FREQ_CONTROL(met[4]), .VARIANCE(variance)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] pk(logic [1:0] r, logic cap, logic stb, logic [2:0] s,
                                      logic sd, logic [7:0] d);
      return {16'h0000, r, cap, stb, s, sd, d};
   endfunction

   // undefined selector codes read as zero
   function automatic logic [7:0] thr(logic [2:0] s, logic sd);
      if (s > 3'd5) return 8'h00;
      return sd ? hi_m[s] : lo_m[s];
   endfunction

   function automatic logic [7:0] smp(logic [2:0] s, logic sd);
      if (s < 3'd5) return met[s];
      return sd ? variance[31:24] : variance[23:16];
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // master holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      read      <= ~wr;
      write     <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic store(input logic [2:0] s, input logic sd, input logic [7:0] d);
      bus(1'b1, OFF_DATA, pk(2'b11, 1'b0, 1'b1, s, sd, d));
   endtask

   task automatic complete_run;
      $display("counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // no test should need more than a few thousand cycles
   initial begin
      #(100 * 20000);
      $display("MISMATCH t=%0t watchdog expired", $time);
      n_errors++;
      complete_run();
   end

   initial begin
      n_errors = 0;
      n_tests = 0;
      nrst = 1'b0;
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      be = 4'hF;
      variance = 32'h0000_0000;
      for (int i = 0; i < 5; i++) met[i] = 8'h80;
      for (int i = 0; i < 6; i++) lo_m[i] = (i == 5) ? RST_VAR_THR : RST_LO_THR;
      for (int i = 0; i < 6; i++) hi_m[i] = (i == 5) ? RST_VAR_THR : RST_HI_THR;
      void'($urandom(32'h1356_7b8b));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rdchk(OFF_DATA, 32'h0000_0000);
      rdchk(OFF_IST, 32'h0000_0000);
      rdchk(OFF_IMASK, 32'h0000_0000);
      chk(irq, 1'b0);
      // strobe with lane 0 off stores the limit byte still held from reset
      be <= 4'h2;
      store(3'd3, 1'b0, 8'h11);
      lo_m[3] = RST_LIMIT_BYTE;
      be <= 4'h1;
      bus(1'b1, OFF_DATA, pk(2'b00, 1'b0, 1'b1, 3'd7, 1'b1, 8'h3C));
      be <= 4'hF;
      rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, 3'd3, 1'b0, RST_LIMIT_BYTE));
      bus(1'b1, 5'h14, 32'hFFFF_FFFF);
      rdchk(5'h14, 32'h0000_0000);
      $display("test reset and unmapped done");
      for (int c = 0; c < 16; c++) begin
         sel = 3'(c >> 1);
         side = c[0];
         b = 8'($urandom);
         store(sel, side, b);
         if (sel < 3'd6 && side) hi_m[sel] = b;
         if (sel < 3'd6 && !side) lo_m[sel] = b;
         rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, sel, side, thr(sel, side)));
      end
      // without the strobe a new byte must not reach any threshold
      for (int c = 0; c < 16; c++) begin
         sel = 3'(c >> 1);
         side = c[0];
         bus(1'b1, OFF_DATA, pk(2'b00, 1'b0, 1'b0, sel, side, ~thr(sel, side)));
         rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, sel, side, thr(sel, side)));
      end
      $display("test threshold store done");
      for (int c = 0; c < 12; c++) begin
         sel = 3'(c >> 1);
         side = c[0];
         for (int i = 0; i < 5; i++) met[i] <= 8'($urandom);
         variance <= $urandom;
         bus(1'b1, OFF_DATA, pk(2'b00, 1'b1, 1'b0, sel, side, 8'h00));
         b = smp(sel, side);
         for (int i = 0; i < 5; i++) met[i] <= 8'($urandom);
         variance <= $urandom;
         rdchk(OFF_DATA, pk(2'b00, 1'b1, 1'b0, sel, side, b));
         bus(1'b0, OFF_IST, 32'h0000_0000);
         chk(rd & 32'h0000_0004, 32'h0000_0004);
         bus(1'b1, OFF_IST, 32'h0000_0007);
      end
      bus(1'b1, OFF_DATA, pk(2'b00, 1'b0, 1'b0, 3'd2, 1'b1, 8'h00));
      rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, 3'd2, 1'b1, thr(3'd2, 1'b1)));
      $display("test live capture done");
      bus(1'b1, OFF_CTRL, 32'h0000_0001);
      bus(1'b1, OFF_IMASK, 32'h0000_0002);
      store(3'd1, 1'b0, 8'h55);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, 3'd1, 1'b0, lo_m[1]));
      bus(1'b0, OFF_IST, 32'h0000_0000);
      chk(rd & 32'h0000_0002, 32'h0000_0002);
      bus(1'b1, OFF_IMASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      bus(1'b1, OFF_IMASK, 32'h0000_0002);
      bus(1'b1, OFF_IST, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      bus(1'b1, OFF_CTRL, 32'h0000_0000);
      store(3'd1, 1'b0, 8'h40);
      lo_m[1] = 8'h40;
      store(3'd1, 1'b1, 8'hC0);
      hi_m[1] = 8'hC0;
      rdchk(OFF_DATA, pk(2'b00, 1'b0, 1'b0, 3'd1, 1'b1, 8'hC0));
      $display("test power-down and interrupt done");
      // earlier random metrics may have left gain flags set: settle and clear them first
      met[1] <= 8'h80;
      repeat (3) @(posedge clk);
      bus(1'b0, OFF_WARN, 32'h0000_0000);
      bus(1'b1, OFF_IST, 32'h0000_0007);
      bus(1'b1, OFF_IMASK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      met[1] <= 8'h10;
      repeat (3) @(posedge clk);
      bus(1'b0, OFF_WARN, 32'h0000_0000);
      chk((rd >> 2) & 32'h0000_0003, 32'h0000_0001);
      chk(irq, 1'b1);
      met[1] <= 8'hF0;
      repeat (3) @(posedge clk);
      bus(1'b0, OFF_WARN, 32'h0000_0000);
      chk((rd >> 2) & 32'h0000_0003, 32'h0000_0003);
      met[1] <= 8'h80;
      repeat (3) @(posedge clk);
      bus(1'b0, OFF_WARN, 32'h0000_0000);
      chk((rd >> 2) & 32'h0000_0003, 32'h0000_0002);
      bus(1'b0, OFF_WARN, 32'h0000_0000);
      chk((rd >> 2) & 32'h0000_0003, 32'h0000_0000);
      $display("test warning flags done");
      complete_run();
   end
endmodule
